// File: hw/configurable_shift_register.sv
// configurable shift register with apb control and a buffered parallel load path
`timescale 1ns/1ps

// Overview of operation
// [RULE_01] The register width is a build parameter of 2 to 512 bits on large parts and 2 to 99 on the rest.
// [RULE_02] Shift register and load buffer updates use one clock edge, rising by default or falling by choice; apb logic is always rising.
// [RULE_03] An optional asynchronous clear of selectable polarity forces all bits and the serial output to zero.
// [RULE_04] An active load enable at the edge copies the parallel word in and the serial output shows its top bit;
// the code copies the oldest buffered word instead, and nothing while the buffer is empty.
// [RULE_05] The load enable may be active low, active high, or left out.
// [RULE_06] When load and shift are requested together the load is done and the shift dropped; with an empty buffer the code drops both.
// [RULE_07] A shift without a load moves bits up by one and puts the serial input into the lowest bit.
// [RULE_08] The shift enable may be active low or active high.
// [RULE_09] Four port arrangements exist and the chosen one decides which data ports are live.
// [RULE_10] The serial-output arrangements keep the register contents internal.
// [RULE_11] The parallel-output arrangements have no serial output.
// [RULE_12] Without a load function the register is built as a serial-input arrangement.
// [RULE_13] A serial output always shows the top bit of the register.
// [RULE_14] With no clear, no load and no shift at an edge the register holds its value.
module configurable_shift_register #(
  parameter int width = shift_pkg::WIDTH_DEFAULT,
  parameter bit large_family = 1'b1,
  parameter shift_pkg::arrangement_e arrangement = shift_pkg::parallel_in_parallel_out,
  parameter bit falling_edge = 1'b0,
  parameter logic [1:0] clear_active_level = shift_pkg::LEVEL_LOW,
  parameter logic [1:0] load_active_level = shift_pkg::LEVEL_HIGH,
  parameter logic [1:0] advance_enable_active_level = shift_pkg::LEVEL_HIGH
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [shift_pkg::ADDR_WIDTH-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic clear_in,
  input wire logic load_enable,
  input wire logic advance_enable,
  input wire logic serial_in,
  input wire logic data_valid,
  output logic data_ready,
  input wire logic [width-1:0] data_in,
  output logic [width-1:0] parallel_out,
  output logic serial_out
);

  // --------------------------------------------------------------------------
  // build-time derivation of the live arrangement
  // --------------------------------------------------------------------------
  localparam int cw = $clog2(shift_pkg::FIFO_DEPTH + 1);
  // width limit depends on the device family; only checked here, not clamped
  localparam int width_max = large_family ? shift_pkg::WIDTH_MAX_LARGE : shift_pkg::WIDTH_MAX_SMALL;
  localparam bit width_ok = (width >= shift_pkg::WIDTH_MIN) && (width <= width_max); // [RULE_01]

  // a register without load can only be filled serially
  localparam bit load_omitted = (load_active_level == shift_pkg::LEVEL_OMITTED);
  localparam shift_pkg::arrangement_e live_arrangement =
    !load_omitted ? arrangement :
    (arrangement == shift_pkg::parallel_in_parallel_out) ? shift_pkg::serial_in_parallel_out :
    (arrangement == shift_pkg::parallel_in_serial_out) ? shift_pkg::serial_in_serial_out :
    arrangement; // [RULE_12]

  // which data ports carry meaning
  localparam bit has_parallel_in = (live_arrangement == shift_pkg::parallel_in_parallel_out) ||
                                   (live_arrangement == shift_pkg::parallel_in_serial_out); // [RULE_09]
  localparam bit has_parallel_out = (live_arrangement == shift_pkg::parallel_in_parallel_out) ||
                                    (live_arrangement == shift_pkg::serial_in_parallel_out); // [RULE_09]
  localparam bit has_serial_out = !has_parallel_out; // [RULE_11]

  // --------------------------------------------------------------------------
  // internal state
  // --------------------------------------------------------------------------
  logic [width-1:0] shift_q;
  logic [width-1:0] fifo_data;
  logic fifo_valid;
  logic [cw-1:0] fifo_count;
  logic [shift_pkg::WORD_SEL_WIDTH-1:0] word_sel;
  shift_pkg::shift_cmd_s sw_cmd;

  // --------------------------------------------------------------------------
  // asynchronous clear
  // --------------------------------------------------------------------------
  // clear is asynchronous by design and so is not synchronised; the function
  // returns zero for the omitted setting, leaving only the bus reset
  wire clear_hit = shift_pkg::is_active(clear_active_level, clear_in); // [RULE_03]
  wire core_rst_n = presetn && !clear_hit; // [RULE_03]

  // --------------------------------------------------------------------------
  // load and shift decisions
  // --------------------------------------------------------------------------
  // pins come from logic on this clock, so they are read without synchronisers
  wire load_pin = has_parallel_in && shift_pkg::is_active(load_active_level, load_enable); // [RULE_05]
  wire load_req = load_pin || (has_parallel_in && sw_cmd.load);
  wire advance_pin = shift_pkg::is_active(advance_enable_active_level, advance_enable); // [RULE_08]
  wire advance_req = advance_pin || sw_cmd.advance;
  // a software shift carries its own serial bit so it cannot race the pin
  wire serial_bit = sw_cmd.advance ? sw_cmd.serial_bit : serial_in;

  // a load with an empty buffer waits: the shift stays blocked so no data slips past
  wire do_load = load_req && fifo_valid; // [RULE_04]
  wire do_shift = advance_req && !load_req; // [RULE_06]

  // --------------------------------------------------------------------------
  // next register value
  // --------------------------------------------------------------------------
  wire [width-1:0] shifted = {shift_q[width-2:0], serial_bit}; // [RULE_07]
  wire [width-1:0] next_shift = do_load ? fifo_data : // [RULE_04]
                                do_shift ? shifted :
                                shift_q; // [RULE_14]
  // serial output follows the new top bit after any update
  wire next_serial_out = has_serial_out ? next_shift[width-1] : 1'b0; // [RULE_13]

  // --------------------------------------------------------------------------
  // register flops on the chosen edge
  // --------------------------------------------------------------------------
  if (falling_edge) begin : g_fall
    always_ff @(negedge pclk or negedge core_rst_n) begin // [RULE_02]
      if (!core_rst_n) begin
        shift_q <= '0; // [RULE_03]
        serial_out <= 1'b0;
      end else begin
        shift_q <= next_shift;
        serial_out <= next_serial_out;
      end
    end
  end else begin : g_rise
    always_ff @(posedge pclk or negedge core_rst_n) begin // [RULE_02]
      if (!core_rst_n) begin
        shift_q <= '0; // [RULE_03]
        serial_out <= 1'b0;
      end else begin
        shift_q <= next_shift;
        serial_out <= next_serial_out;
      end
    end
  end

  // parallel bus exists only in the parallel-output arrangements
  assign parallel_out = has_parallel_out ? shift_q : '0; // [RULE_10]

  // --------------------------------------------------------------------------
  // load data buffer
  // --------------------------------------------------------------------------
  // the buffer is only filled when a parallel input exists; otherwise the
  // source sees data_ready held high by the empty fifo, so its words are dropped
  wire fill_valid = data_valid && has_parallel_in;

  fifo_buffer #(
    .data_width(width),
    .depth(shift_pkg::FIFO_DEPTH),
    .falling_edge(falling_edge)
  ) u_load_fifo (
    .clk(pclk),
    .rst_n(presetn),
    .in_valid(fill_valid),
    .in_ready(data_ready),
    .in_data(data_in),
    .out_valid(fifo_valid),
    .out_ready(do_load),
    .out_data(fifo_data),
    .count(fifo_count)
  );

  wire fifo_full = !data_ready;

  // --------------------------------------------------------------------------
  // apb address decode
  // --------------------------------------------------------------------------
  wire apb_setup = psel && !penable;
  wire apb_access = psel && penable && pready;
  wire hit_command = (paddr == shift_pkg::COMMAND_OFFSET);
  wire hit_status = (paddr == shift_pkg::STATUS_OFFSET);
  wire hit_word_sel = (paddr == shift_pkg::WORD_SEL_OFFSET);
  wire hit_value = (paddr == shift_pkg::VALUE_OFFSET);
  wire mapped = hit_command || hit_status || hit_word_sel || hit_value;
  wire write_ok = apb_access && pwrite && !pslverr;

  // --------------------------------------------------------------------------
  // read data
  // --------------------------------------------------------------------------
  wire [31:0] status_word = (32'(fifo_count) << shift_pkg::STAT_COUNT_POS) |
                            (32'(fifo_full) << shift_pkg::STAT_FULL_POS) |
                            (32'(!fifo_valid) << shift_pkg::STAT_EMPTY_POS) |
                            (32'(serial_out) << shift_pkg::STAT_SERIAL_POS);
  // widened copy so any width can be read in aligned 32-bit slices
  wire [shift_pkg::WIDTH_MAX_LARGE-1:0] wide_value = shift_pkg::WIDTH_MAX_LARGE'(shift_q);
  wire [31:0] value_slice = wide_value[32*word_sel +: 32];
  // serial-output builds keep the contents private, even from software
  wire [31:0] value_word = has_parallel_out ? value_slice : 32'h0000_0000; // [RULE_10]
  wire [31:0] word_sel_word = 32'(word_sel);
  wire [31:0] read_mux = hit_status ? status_word :
                         hit_word_sel ? word_sel_word :
                         hit_value ? value_word :
                         32'h0000_0000;

  // --------------------------------------------------------------------------
  // apb response, one access cycle with no wait states
  // --------------------------------------------------------------------------
  // read data is captured at the setup edge so it stands still for the whole access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= shift_pkg::READ_RESET;
    end else begin
      pready <= apb_setup;
      pslverr <= apb_setup && !mapped;
      prdata <= (apb_setup && !pwrite && mapped) ? read_mux : shift_pkg::READ_RESET;
    end
  end

  // --------------------------------------------------------------------------
  // software controls
  // --------------------------------------------------------------------------
  // command bits become a one-cycle pulse; a falling-edge register samples it
  // at the negedge in the middle of the pulse, so it acts exactly once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_cmd <= shift_pkg::CMD_IDLE;
      word_sel <= shift_pkg::WORD_SEL_RESET;
    end else begin
      if (write_ok && hit_command) begin
        sw_cmd.load <= pwdata[shift_pkg::CMD_LOAD_POS];
        sw_cmd.advance <= pwdata[shift_pkg::CMD_ADVANCE_POS];
        sw_cmd.serial_bit <= pwdata[shift_pkg::CMD_SERIAL_POS];
      end else begin
        sw_cmd <= shift_pkg::CMD_IDLE;
      end
      if (write_ok && hit_word_sel) begin
        word_sel <= pwdata[shift_pkg::WORD_SEL_WIDTH-1:0];
      end
    end
  end

  // width_ok documents the legal range for the chosen family; it is kept for
  // readability of the build settings and drives no logic
  wire unused_width_ok = width_ok;

endmodule : configurable_shift_register

// File: hw/fifo_buffer.sv
// parameterised flip-flop fifo holding parallel load words
`timescale 1ns/1ps

module fifo_buffer #(
  parameter int data_width = 8,
  parameter int depth = 16,
  parameter bit falling_edge = 1'b0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [data_width-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [data_width-1:0] out_data,
  output logic [$clog2(depth+1)-1:0] count
);

  localparam int aw = $clog2(depth);
  localparam int cw = $clog2(depth+1);
  localparam logic [cw-1:0] full_count = cw'(depth);

  logic [data_width-1:0] mem [depth];
  logic [aw-1:0] wr_ptr;
  logic [aw-1:0] rd_ptr;

  // --------------------------------------------------------------------------
  // handshake and next state
  // --------------------------------------------------------------------------
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  wire [cw-1:0] next_count = cw'(count + cw'(push) - cw'(pop));
  wire [aw-1:0] next_wr_ptr = push ? aw'(wr_ptr + 1'b1) : wr_ptr;
  wire [aw-1:0] next_rd_ptr = pop ? aw'(rd_ptr + 1'b1) : rd_ptr;
  // ready is registered so the source sees it straight from a flop
  wire next_in_ready = (next_count != full_count);

  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];

  // --------------------------------------------------------------------------
  // storage on the same edge as the shift register that drains it
  // --------------------------------------------------------------------------
  if (falling_edge) begin : g_fall
    always_ff @(negedge clk or negedge rst_n) begin
      if (!rst_n) begin
        wr_ptr <= '0;
        rd_ptr <= '0;
        count <= '0;
        in_ready <= 1'b1;
      end else begin
        wr_ptr <= next_wr_ptr;
        rd_ptr <= next_rd_ptr;
        count <= next_count;
        in_ready <= next_in_ready;
      end
    end
    // data words need no reset, only the pointers, count and ready flag do
    always_ff @(negedge clk) begin
      if (push) begin
        mem[wr_ptr] <= in_data;
      end
    end
  end else begin : g_rise
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        wr_ptr <= '0;
        rd_ptr <= '0;
        count <= '0;
        in_ready <= 1'b1;
      end else begin
        wr_ptr <= next_wr_ptr;
        rd_ptr <= next_rd_ptr;
        count <= next_count;
        in_ready <= next_in_ready;
      end
    end
    always_ff @(posedge clk) begin
      if (push) begin
        mem[wr_ptr] <= in_data;
      end
    end
  end

endmodule : fifo_buffer

// File: hw/shift_pkg.sv
// shared types, register map and constants for the configurable shift register
package shift_pkg;

  // --------------------------------------------------------------------------
  // build-time choices
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    parallel_in_parallel_out,
    parallel_in_serial_out,
    serial_in_parallel_out,
    serial_in_serial_out
  } arrangement_e;

  // active level settings shared by clear, load and advance enables
  localparam logic [1:0] LEVEL_LOW = 2'h0;
  localparam logic [1:0] LEVEL_HIGH = 2'h1;
  localparam logic [1:0] LEVEL_OMITTED = 2'h2;

  // legal register widths
  localparam int WIDTH_MIN = 2;
  localparam int WIDTH_MAX_LARGE = 512;
  localparam int WIDTH_MAX_SMALL = 99;
  localparam int WIDTH_DEFAULT = 8;

  // load data buffer
  localparam int FIFO_DEPTH = 16;

  // --------------------------------------------------------------------------
  // register map (byte addresses, one 32-bit word each)
  // --------------------------------------------------------------------------
  localparam int ADDR_WIDTH = 12;
  localparam logic [11:0] COMMAND_OFFSET = 12'h000;
  localparam logic [11:0] STATUS_OFFSET = 12'h004;
  localparam logic [11:0] WORD_SEL_OFFSET = 12'h008;
  localparam logic [11:0] VALUE_OFFSET = 12'h00C;

  // command register fields (write-only pulses)
  localparam int CMD_LOAD_POS = 0;
  localparam int CMD_ADVANCE_POS = 1;
  localparam int CMD_SERIAL_POS = 2;

  // status register fields
  localparam int STAT_SERIAL_POS = 0;
  localparam int STAT_EMPTY_POS = 1;
  localparam int STAT_FULL_POS = 2;
  localparam int STAT_COUNT_POS = 8;

  // word select register
  localparam int WORD_SEL_WIDTH = 4;
  localparam logic [3:0] WORD_SEL_RESET = 4'h0;
  localparam logic [31:0] READ_RESET = 32'h0000_0000;

  // software command bundle, one cycle wide
  typedef struct packed {
    logic load;
    logic advance;
    logic serial_bit;
  } shift_cmd_s;

  localparam shift_cmd_s CMD_IDLE = '{load: 1'b0, advance: 1'b0, serial_bit: 1'b0};

  // true when a control pin sits at its configured active level
  function automatic logic is_active(input logic [1:0] level, input logic pin);
    logic hit;
    hit = 1'b0;
    if (level == LEVEL_LOW) begin
      hit = ~pin;
    end else if (level == LEVEL_HIGH) begin
      hit = pin;
    end
    return hit;
  endfunction : is_active

endpackage : shift_pkg

// File: verif/configurable_shift_register_tb.sv
// self-checking bench for the configurable shift register
`timescale 1ns/1ps

module configurable_shift_register_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic clear_in, load_enable, advance_enable, serial_in, data_valid, data_ready, serial_out;
  logic [7:0] data_in, parallel_out, exp;
  int fails, checked, cycles;

  configurable_shift_register configurable_shift_register_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .clear_in(clear_in), .load_enable(load_enable), .advance_enable(advance_enable),
    .serial_in(serial_in), .data_valid(data_valid), .data_ready(data_ready), .data_in(data_in),
    .parallel_out(parallel_out), .serial_out(serial_out));
  load_source #(.width(8)) load_source_i (.pclk(pclk), .presetn(presetn), .data_ready(data_ready),
    .data_valid(data_valid), .data_in(data_in));

  // ----------------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checked++;
    if (seen !== want) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check

  // apb transfer; waits for ready with no assumed wait count, only the watchdog ends a hang
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // one core edge with the given pins, then idle; ends at the falling edge where outputs are settled
  task automatic core_op(input logic ld, input logic adv, input logic sin);
    @(posedge pclk);
    load_enable <= ld;
    advance_enable <= adv;
    serial_in <= sin;
    @(posedge pclk);
    load_enable <= 1'b0;
    advance_enable <= 1'b0;
    serial_in <= ~sin;
    @(negedge pclk);
  endtask : core_op

  task automatic push_wait(input logic [7:0] w);
    load_source_i.pending.push_back(w);
    for (int i = 0; i < 100 && load_source_i.pending.size() != 0; i++) @(posedge pclk);
    repeat (3) @(posedge pclk);
  endtask : push_wait

  // ----------------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------------
  task automatic t_regs;
    apb(1'b0, shift_pkg::STATUS_OFFSET, 32'h0);
    check(rd, 32'h0000_0002);
    apb(1'b0, shift_pkg::WORD_SEL_OFFSET, 32'h0);
    check(rd, 32'h0000_0000);
    apb(1'b1, shift_pkg::WORD_SEL_OFFSET, 32'hFFFF_FFFF);
    apb(1'b0, shift_pkg::WORD_SEL_OFFSET, 32'h0);
    check(rd, 32'h0000_000F);
    apb(1'b0, shift_pkg::VALUE_OFFSET, 32'h0);
    check(rd, 32'h0000_0000);
    apb(1'b1, shift_pkg::WORD_SEL_OFFSET, 32'h0);
    apb(1'b1, 12'h010, 32'h1);
    check(32'(err), 32'h1);
    apb(1'b0, shift_pkg::COMMAND_OFFSET, 32'h0);
    check({rd[31:1], err}, 32'h0);
    $display("test regs done");
  endtask : t_regs

  task automatic t_shift;
    exp = 8'h00;
    for (int i = 7; i >= 0; i--) begin
      core_op(1'b0, 1'b1, exp[0] ^ 1'(i % 3 == 0));
      exp = {exp[6:0], ~serial_in};
      check(32'(parallel_out), 32'(exp));
    end
    core_op(1'b0, 1'b0, 1'b1);
    check(32'(parallel_out), 32'(exp));
    check(32'(serial_out), 32'h0);
    apb(1'b0, shift_pkg::VALUE_OFFSET, 32'h0);
    check(rd, 32'(exp));
    $display("test shift done");
  endtask : t_shift

  task automatic t_load;
    push_wait(8'hA5);
    core_op(1'b1, 1'b1, 1'b1);
    check(32'(parallel_out), 32'h0000_00A5);
    core_op(1'b1, 1'b1, 1'b0);
    check(32'(parallel_out), 32'h0000_00A5);
    core_op(1'b0, 1'b1, 1'b1);
    check(32'(parallel_out), 32'h0000_004B);
    $display("test load done");
  endtask : t_load

  task automatic t_clear;
    push_wait(8'h5A);
    @(posedge pclk);
    clear_in <= 1'b0;
    @(negedge pclk);
    check(32'(parallel_out), 32'h0);
    core_op(1'b0, 1'b1, 1'b1);
    check(32'(parallel_out), 32'h0);
    @(posedge pclk);
    clear_in <= 1'b1;
    core_op(1'b1, 1'b0, 1'b0);
    check(32'(parallel_out), 32'h0000_005A);
    $display("test clear done");
  endtask : t_clear

  // fill past sixteen words so the buffer refuses, then drain it with the source stalling
  task automatic t_fifo;
    for (int i = 0; i < 17; i++) load_source_i.pending.push_back(8'(8'h10 + i));
    for (int i = 0; i < 200 && data_ready !== 1'b0; i++) @(posedge pclk);
    check(32'(data_ready), 32'h0);
    apb(1'b0, shift_pkg::STATUS_OFFSET, 32'h0);
    check(rd, 32'h0000_1004);
    load_source_i.stall_cycles = 3;
    for (int i = 0; i < 17; i++) begin
      core_op(1'b1, 1'b0, 1'b0);
      check(32'(parallel_out), 32'(8'h10 + i));
    end
    load_source_i.stall_cycles = 0;
    apb(1'b0, shift_pkg::STATUS_OFFSET, 32'h0);
    check(rd, 32'h0000_0002);
    $display("test fifo done");
  endtask : t_fifo

  task automatic t_sw;
    apb(1'b1, shift_pkg::COMMAND_OFFSET, 32'h0000_0006);
    @(posedge pclk);
    @(negedge pclk);
    check(32'(parallel_out), 32'h0000_0041);
    push_wait(8'h77);
    apb(1'b1, shift_pkg::COMMAND_OFFSET, 32'h0000_0003);
    @(posedge pclk);
    @(negedge pclk);
    check(32'(parallel_out), 32'h0000_0077);
    $display("test software done");
  endtask : t_sw

  task automatic summarize;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize

  // ----------------------------------------------------------------------------
  // clock, watchdog and main sequence
  // ----------------------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // the whole run needs well under a thousand cycles
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      summarize();
    end
  end

  initial begin
    {presetn, psel, penable, pwrite, load_enable, advance_enable, serial_in} = '0;
    clear_in = 1'b1;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    check(32'(parallel_out), 32'h0);
    check(32'(data_ready), 32'h1);
    t_regs();
    t_shift();
    t_load();
    t_clear();
    t_fifo();
    t_sw();
    summarize();
  end
endmodule : configurable_shift_register_tb

// File: verif/load_source.sv
// stream source standing in for the user logic that feeds parallel load words
`timescale 1ns/1ps

module load_source #(
  parameter int width = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic data_ready,
  output logic data_valid,
  output logic [width-1:0] data_in
);
  logic [width-1:0] pending[$];
  int stall_cycles = 0;
  int gap;

  // word held until accepted; released data shows its inverse, never a stale copy
  // one process drives the stream pins, reset included, so each has a single driver
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_valid <= 1'b0;
      data_in <= '0;
      gap = 0;
    end else if (data_valid && data_ready) begin
      void'(pending.pop_front());
      gap = stall_cycles;
      if (pending.size() > 0 && gap == 0) begin
        data_in <= pending[0];
      end else begin
        data_valid <= 1'b0;
        data_in <= ~data_in;
      end
    end else if (!data_valid && pending.size() > 0) begin
      if (gap > 0) begin
        gap--;
      end else begin
        data_valid <= 1'b1;
        data_in <= pending[0];
      end
    end
  end
endmodule : load_source

// File: verif/shift_chk.sv
// port checks for the shift register built parallel-in/parallel-out, active-low clear
`timescale 1ns/1ps

module shift_chk #(
  parameter int width = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [shift_pkg::ADDR_WIDTH-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic clear_in,
  input wire logic load_enable,
  input wire logic advance_enable,
  input wire logic serial_in,
  input wire logic data_valid,
  input wire logic data_ready,
  input wire logic [width-1:0] data_in,
  input wire logic [width-1:0] parallel_out,
  input wire logic serial_out
);
  // a command write acts one edge later, so pin shifts are not judged then
  logic cmd_pend;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_pend <= 1'b0;
    end else begin
      cmd_pend <= psel && penable && pready && pwrite && (paddr == shift_pkg::COMMAND_OFFSET);
    end
  end
  wire logic quiet = !cmd_pend && !load_enable && clear_in;

  sequence setup_s;
    psel && !penable;
  endsequence
  sequence access_s;
    psel && penable && pready;
  endsequence

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_clear_zeroes: assert property (!clear_in |-> parallel_out == '0 && !serial_out)
    else $error("clear did not zero the register");
  chk_shift_step: assert property (quiet && advance_enable |=>
    !clear_in || parallel_out == {$past(parallel_out[width-2:0]), $past(serial_in)})
    else $error("shift result wrong");
  chk_idle_hold: assert property (quiet && !advance_enable |=> !clear_in || $stable(parallel_out))
    else $error("register changed while idle");
  chk_no_serial: assert property (serial_out == 1'b0)
    else $error("serial output active in a parallel-out build");
  chk_setup_answer: assert property (setup_s |=> access_s)
    else $error("no ready in the access cycle");
  chk_ready_once: assert property (access_s |=> !pready)
    else $error("ready held past the access cycle");
  chk_ready_cause: assert property (pready |-> $past(psel && !penable) && psel && penable)
    else $error("ready without a setup");
  chk_error_map: assert property (pready && paddr[1:0] == 2'h0 |-> pslverr == (paddr[11:4] != 8'h00))
    else $error("error response wrong for address");
  chk_read_idle: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("read data outside access cycle");
endmodule : shift_chk

bind configurable_shift_register shift_chk #(.width(width)) shift_chk_i (.*);
